// [common/lccr_pkg.sv]
// Constants and types shared by the line interface control register bank
// Summary of operation
// - Loopback register bit n set enables digital loopback on channel n.
// - All registers hold zero after power-up and after any reset.
// - At 1.544 Mbps detect variant bits are ignored; ANSI detection used.
// - At 2.048 Mbps bit n one selects ETSI detection, zero selects G.775.
// - Auto all-ones bit n plus loss of signal sends all-ones on channel n.
// - Global bit 7 set: phase address increments after each table access.
// - Global bit 6 set: loss of signal inserts receive all-ones alarm.
// - Global bit 4 zero: B8ZS at 1.544 Mbps, HDB3 at 2.048 Mbps.
// - Global bit 3 sets attenuator FIFO depth: 32 if zero, 64 if one.
// - Global bit 2 picks attenuator corner frequency, per line rate.
// - Global bits 1:0: 01 transmit path, 10 disabled, 11 receive path.
// - Three-bit channel pointer selects channel for line-length data.
// - Line-length data accesses go to the channel held in the pointer.
// - Any write to the software reset register restores all defaults.
// - Stored line-length code sets impedance and pulse shape per channel.
package lccr_pkg;
  localparam int NCH      = 8;
  localparam int DW       = 8;
  localparam int AW       = 8;
  localparam int PTR_W    = 3;
  localparam int LL_W     = 5;
  localparam int LEN_W    = 4;
  localparam int CHZ_W    = 10;
  localparam int DEPTH_W  = 7;
  localparam int PHASE_W  = 4;

  localparam logic [AW-1:0] ADDR_SRESET    = 8'h0A;
  localparam logic [AW-1:0] ADDR_LOOPBACK  = 8'h0C;
  localparam logic [AW-1:0] ADDR_DETECT    = 8'h0D;
  localparam logic [AW-1:0] ADDR_AUTO_ONES = 8'h0E;
  localparam logic [AW-1:0] ADDR_GLOBAL    = 8'h0F;
  localparam logic [AW-1:0] ADDR_LL_PTR    = 8'h10;
  localparam logic [AW-1:0] ADDR_LL_DATA   = 8'h11;
  localparam logic [AW-1:0] ADDR_WAVE_ADDR = 8'h17;

  localparam logic [DW-1:0] REG_RESET = 8'h00;

  localparam int GC_AUTO_INC = 7;
  localparam int GC_RX_AIS   = 6;
  localparam int GC_CODE     = 4;
  localparam int GC_FIFO     = 3;
  localparam int GC_CORNER   = 2;
  localparam int GC_PLACE_HI = 1;
  localparam int GC_PLACE_LO = 0;

  localparam int LL_INT_BIT  = 4;
  localparam int LEN_E1_MSB  = 3;
  localparam logic [LEN_W-1:0] LEN_E1_120 = 4'h0;

  localparam logic [1:0] PLACE_ENC_TX = 2'h1;
  localparam logic [1:0] PLACE_ENC_RX = 2'h3;

  localparam logic [DEPTH_W-1:0] JAT_DEPTH_SHORT = 7'h20;
  localparam logic [DEPTH_W-1:0] JAT_DEPTH_LONG  = 7'h40;

  // Corner frequencies in hundredths of a hertz
  localparam logic [CHZ_W-1:0] CORNER_E1_LO_CHZ = 10'h07D;
  localparam logic [CHZ_W-1:0] CORNER_E1_HI_CHZ = 10'h0FA;
  localparam logic [CHZ_W-1:0] CORNER_T1_LO_CHZ = 10'h17A;
  localparam logic [CHZ_W-1:0] CORNER_T1_HI_CHZ = 10'h2F4;

  typedef enum logic [1:0] {
    LCCR_PLACE_OFF = 2'b00,
    LCCR_PLACE_TX  = 2'b01,
    LCCR_PLACE_RX  = 2'b10
  } lccr_place_t;

  typedef enum logic [1:0] {
    LCCR_CODE_AMI  = 2'b00,
    LCCR_CODE_B8ZS = 2'b01,
    LCCR_CODE_HDB3 = 2'b10
  } lccr_code_t;
endpackage : lccr_pkg

// [common/lccr_ll_if.sv]
// Link between the register bank and the per-channel line-length store
`timescale 1ns/1ps
interface lccr_ll_if;
  logic [lccr_pkg::PTR_W-1:0] ptr;
  logic                       wr;
  logic                       clr;
  logic [lccr_pkg::LL_W-1:0]  wdata;
  logic [lccr_pkg::LL_W-1:0]  rdata;
  logic [lccr_pkg::NCH-1:0][lccr_pkg::LL_W-1:0] cfg;

  modport ctrl (
    output ptr,
    output wr,
    output clr,
    output wdata,
    input  rdata,
    input  cfg
  );

  modport store (
    input  ptr,
    input  wr,
    input  clr,
    input  wdata,
    output rdata,
    output cfg
  );
endinterface : lccr_ll_if

// [hdl/lccr_sync.sv]
// Two flip-flop synchroniser for host pins
`timescale 1ns/1ps
module lccr_sync #(
  parameter int           W       = 1,
  parameter logic [W-1:0] RST_VAL = '0
) (
  input  wire logic         clk,
  input  wire logic         rst,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  logic [W-1:0] meta_reg;
  logic [W-1:0] meta_next;
  logic [W-1:0] sync_reg;
  logic [W-1:0] sync_next;

  always_comb begin
    meta_next = d;
    sync_next = meta_reg;
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      meta_reg <= RST_VAL;
      sync_reg <= RST_VAL;
    end else begin
      meta_reg <= meta_next;
      sync_reg <= sync_next;
    end
  end

  assign q = sync_reg;
endmodule : lccr_sync

// [hdl/lccr_line_length_store.sv]
// Per-channel line-length codes, reached through the channel pointer
`timescale 1ns/1ps
module lccr_line_length_store (
  input  wire logic clk,
  input  wire logic rst,
  lccr_ll_if.store  ll
);
  logic [lccr_pkg::NCH-1:0][lccr_pkg::LL_W-1:0] cfg_reg;
  logic [lccr_pkg::NCH-1:0][lccr_pkg::LL_W-1:0] cfg_next;

  always_comb begin
    cfg_next = cfg_reg;
    if (ll.clr) begin
      cfg_next = '0;
    end else if (ll.wr) begin
      cfg_next[ll.ptr] = ll.wdata;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cfg_reg <= '0;
    end else begin
      cfg_reg <= cfg_next;
    end
  end

  assign ll.rdata = cfg_reg[ll.ptr];
  assign ll.cfg   = cfg_reg;
endmodule : lccr_line_length_store

// [hdl/lccr_channel_control_regs.sv]
// Host-facing control register bank for the eight-channel line interface
`timescale 1ns/1ps
module lccr_channel_control_regs (
  input  wire logic                    mclk,
  input  wire logic                    rst,
  input  wire logic                    host_cs_n,
  input  wire logic                    host_rd_n,
  input  wire logic                    host_wr_n,
  input  wire logic [lccr_pkg::AW-1:0] host_addr,
  input  wire logic [lccr_pkg::DW-1:0] host_data_in,
  output logic      [lccr_pkg::DW-1:0] host_data_out,
  output logic                         host_data_oe,
  input  wire logic [lccr_pkg::NCH-1:0] chan_los,
  input  wire logic                    wave_table_access,
  output logic      [lccr_pkg::NCH-1:0] loopback_en,
  output logic      [lccr_pkg::NCH-1:0] chan_e1,
  output logic      [lccr_pkg::NCH-1:0] detect_etsi,
  output logic      [lccr_pkg::NCH-1:0] tx_all_ones,
  output logic      [lccr_pkg::NCH-1:0] rx_ais_insert,
  output logic      [lccr_pkg::NCH-1:0][1:0] line_code,
  output logic      [lccr_pkg::DEPTH_W-1:0] jat_fifo_depth,
  output logic      [lccr_pkg::NCH-1:0][lccr_pkg::CHZ_W-1:0] jat_corner_chz,
  output lccr_pkg::lccr_place_t       jat_place,
  output logic                         wave_auto_inc,
  output logic      [lccr_pkg::DW-1:0] wave_phase_addr,
  output logic      [lccr_pkg::NCH-1:0] ll_impedance_int,
  output logic      [lccr_pkg::NCH-1:0][lccr_pkg::LEN_W-1:0] ll_len
);

  // Synchronised host pins
  logic [2:0]                       strobe_s;
  logic [lccr_pkg::AW+lccr_pkg::DW-1:0] bus_s;
  logic [lccr_pkg::AW-1:0]          addr_s;
  logic [lccr_pkg::DW-1:0]          data_s;

  // Access detection
  logic wr_act;
  logic rd_act;
  logic wr_pulse;
  logic sreset_pulse;
  logic wr_act_reg;
  logic wr_act_next;

  // Control registers
  logic [lccr_pkg::DW-1:0]    loopback_reg;
  logic [lccr_pkg::DW-1:0]    loopback_next;
  logic [lccr_pkg::DW-1:0]    detect_reg;
  logic [lccr_pkg::DW-1:0]    detect_next;
  logic [lccr_pkg::DW-1:0]    auto_ones_reg;
  logic [lccr_pkg::DW-1:0]    auto_ones_next;
  logic [lccr_pkg::DW-1:0]    global_reg;
  logic [lccr_pkg::DW-1:0]    global_next;
  logic [lccr_pkg::PTR_W-1:0] ptr_reg;
  logic [lccr_pkg::PTR_W-1:0] ptr_next;
  logic [lccr_pkg::DW-1:0]    wave_addr_reg;
  logic [lccr_pkg::DW-1:0]    wave_addr_next;

  // Host read side
  logic [lccr_pkg::DW-1:0] rdata_reg;
  logic [lccr_pkg::DW-1:0] rdata_next;
  logic                    oe_reg;
  logic                    oe_next;

  // Registered channel controls
  logic [lccr_pkg::NCH-1:0]      e1_reg;
  logic [lccr_pkg::NCH-1:0]      e1_next;
  logic [lccr_pkg::NCH-1:0]      etsi_reg;
  logic [lccr_pkg::NCH-1:0]      etsi_next;
  logic [lccr_pkg::NCH-1:0]      tx_ones_reg;
  logic [lccr_pkg::NCH-1:0]      tx_ones_next;
  logic [lccr_pkg::NCH-1:0]      rx_ais_reg;
  logic [lccr_pkg::NCH-1:0]      rx_ais_next;
  logic [lccr_pkg::NCH-1:0][1:0] code_reg;
  logic [lccr_pkg::NCH-1:0][1:0] code_next;
  logic [lccr_pkg::NCH-1:0][lccr_pkg::CHZ_W-1:0] corner_reg;
  logic [lccr_pkg::NCH-1:0][lccr_pkg::CHZ_W-1:0] corner_next;
  logic [lccr_pkg::DEPTH_W-1:0]  depth_reg;
  logic [lccr_pkg::DEPTH_W-1:0]  depth_next;
  lccr_pkg::lccr_place_t         place_reg;
  lccr_pkg::lccr_place_t         place_next;

  // The line-length store is reached only through the channel pointer,
  // so one host port serves all eight channels
  lccr_ll_if ll_bus ();

  lccr_sync #(
    .W       (3),
    .RST_VAL (3'h7)
  ) u_strobe_sync (
    .clk (mclk),
    .rst (rst),
    .d   ({host_cs_n, host_rd_n, host_wr_n}),
    .q   (strobe_s)
  );

  // Address and data pass the same two stages as the strobes, so they
  // line up with the strobe edge when the host holds them across it
  lccr_sync #(
    .W       (lccr_pkg::AW + lccr_pkg::DW),
    .RST_VAL (16'h0000)
  ) u_bus_sync (
    .clk (mclk),
    .rst (rst),
    .d   ({host_addr, host_data_in}),
    .q   (bus_s)
  );

  lccr_line_length_store u_ll_store (
    .clk (mclk),
    .rst (rst),
    .ll  (ll_bus.store)
  );

  assign addr_s = bus_s[lccr_pkg::AW+lccr_pkg::DW-1:lccr_pkg::DW];
  assign data_s = bus_s[lccr_pkg::DW-1:0];

  // Strobe decode; a write commits once, on the start of the strobe
  // Strobes reset to idle high, so no false write edge follows reset
  always_comb begin
    wr_act       = ~strobe_s[2] & ~strobe_s[0];
    rd_act       = ~strobe_s[2] & ~strobe_s[1];
    wr_pulse     = wr_act & ~wr_act_reg;
    sreset_pulse = wr_pulse & (addr_s == lccr_pkg::ADDR_SRESET);
    wr_act_next  = wr_act;
  end

  assign ll_bus.ptr   = ptr_reg;
  assign ll_bus.clr   = sreset_pulse;
  assign ll_bus.wr    = wr_pulse & (addr_s == lccr_pkg::ADDR_LL_DATA);
  assign ll_bus.wdata = data_s[lccr_pkg::LL_W-1:0];

  // Register writes, software reset and phase address stepping
  // A software reset or a host write to the phase address wins over a same-cycle phase step
  always_comb begin
    loopback_next  = loopback_reg;
    detect_next    = detect_reg;
    auto_ones_next = auto_ones_reg;
    global_next    = global_reg;
    ptr_next       = ptr_reg;
    wave_addr_next = wave_addr_reg;
    if (global_reg[lccr_pkg::GC_AUTO_INC] && wave_table_access) begin
      // Only the phase field steps; it wraps inside its own width
      wave_addr_next[lccr_pkg::PHASE_W-1:0] =
        wave_addr_reg[lccr_pkg::PHASE_W-1:0] + 4'h1;
    end
    if (sreset_pulse) begin
      loopback_next  = lccr_pkg::REG_RESET;
      detect_next    = lccr_pkg::REG_RESET;
      auto_ones_next = lccr_pkg::REG_RESET;
      global_next    = lccr_pkg::REG_RESET;
      ptr_next       = '0;
      wave_addr_next = lccr_pkg::REG_RESET;
    end else if (wr_pulse) begin
      unique case (addr_s)
        lccr_pkg::ADDR_LOOPBACK:  loopback_next  = data_s;
        lccr_pkg::ADDR_DETECT:    detect_next    = data_s;
        lccr_pkg::ADDR_AUTO_ONES: auto_ones_next = data_s;
        lccr_pkg::ADDR_GLOBAL:    global_next    = data_s;
        // Reserved pointer bits are dropped and read back as zero
        lccr_pkg::ADDR_LL_PTR:
          ptr_next = data_s[lccr_pkg::PTR_W-1:0];
        lccr_pkg::ADDR_WAVE_ADDR: wave_addr_next = data_s;
        default: begin
        end
      endcase
    end
  end

  // Read mux; unmapped addresses and the reset register read as zero
  // The enable follows the synced strobe, three edges behind the pins
  always_comb begin
    oe_next    = rd_act;
    rdata_next = rdata_reg;
    if (rd_act) begin
      unique case (addr_s)
        lccr_pkg::ADDR_LOOPBACK:  rdata_next = loopback_reg;
        lccr_pkg::ADDR_DETECT:    rdata_next = detect_reg;
        lccr_pkg::ADDR_AUTO_ONES: rdata_next = auto_ones_reg;
        lccr_pkg::ADDR_GLOBAL:    rdata_next = global_reg;
        lccr_pkg::ADDR_LL_PTR:
          rdata_next = {5'h00, ptr_reg};
        lccr_pkg::ADDR_LL_DATA:
          rdata_next = {3'h0, ll_bus.rdata};
        lccr_pkg::ADDR_WAVE_ADDR: rdata_next = wave_addr_reg;
        default:                  rdata_next = lccr_pkg::REG_RESET;
      endcase
    end
  end

  // Per-channel controls; the alarm, code and corner fields fan out to all channels
  // Rate is derived from each stored code; no pin tells the block
  always_comb begin
    e1_next     = '0;
    etsi_next   = '0;
    tx_ones_next = '0;
    rx_ais_next = '0;
    code_next   = '0;
    corner_next = '0;
    for (int i = 0; i < lccr_pkg::NCH; i++) begin
      // Codes with bit 3 set or with length bits 3:0 all zero are 2.048 Mbps
      e1_next[i] = (ll_bus.cfg[i][lccr_pkg::LEN_W-1:0] ==
                    lccr_pkg::LEN_E1_120) |
                   ll_bus.cfg[i][lccr_pkg::LEN_E1_MSB];
      // At 1.544 Mbps the variant bit is masked off
      etsi_next[i] = e1_next[i] & detect_reg[i];
      tx_ones_next[i] = auto_ones_reg[i] & chan_los[i];
      rx_ais_next[i] = global_reg[lccr_pkg::GC_RX_AIS] &
                       chan_los[i];
      if (global_reg[lccr_pkg::GC_CODE]) begin
        code_next[i] = lccr_pkg::LCCR_CODE_AMI;
      end else if (e1_next[i]) begin
        code_next[i] = lccr_pkg::LCCR_CODE_HDB3;
      end else begin
        code_next[i] = lccr_pkg::LCCR_CODE_B8ZS;
      end
      unique case ({e1_next[i], global_reg[lccr_pkg::GC_CORNER]})
        2'b10: corner_next[i] = lccr_pkg::CORNER_E1_LO_CHZ;
        2'b11: corner_next[i] = lccr_pkg::CORNER_E1_HI_CHZ;
        2'b00: corner_next[i] = lccr_pkg::CORNER_T1_LO_CHZ;
        2'b01: corner_next[i] = lccr_pkg::CORNER_T1_HI_CHZ;
      endcase
    end
    depth_next = global_reg[lccr_pkg::GC_FIFO] ?
                 lccr_pkg::JAT_DEPTH_LONG :
                 lccr_pkg::JAT_DEPTH_SHORT;
    unique case (global_reg[lccr_pkg::GC_PLACE_HI:lccr_pkg::GC_PLACE_LO])
      lccr_pkg::PLACE_ENC_TX: place_next = lccr_pkg::LCCR_PLACE_TX;
      lccr_pkg::PLACE_ENC_RX: place_next = lccr_pkg::LCCR_PLACE_RX;
      // Code 00 has no defined position, so it parks the attenuator
      default: place_next = lccr_pkg::LCCR_PLACE_OFF;
    endcase
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      wr_act_reg    <= 1'b0;
      loopback_reg  <= lccr_pkg::REG_RESET;
      detect_reg    <= lccr_pkg::REG_RESET;
      auto_ones_reg <= lccr_pkg::REG_RESET;
      global_reg    <= lccr_pkg::REG_RESET;
      ptr_reg       <= '0;
      wave_addr_reg <= lccr_pkg::REG_RESET;
      rdata_reg     <= lccr_pkg::REG_RESET;
      oe_reg        <= 1'b0;
    end else begin
      wr_act_reg    <= wr_act_next;
      loopback_reg  <= loopback_next;
      detect_reg    <= detect_next;
      auto_ones_reg <= auto_ones_next;
      global_reg    <= global_next;
      ptr_reg       <= ptr_next;
      wave_addr_reg <= wave_addr_next;
      rdata_reg     <= rdata_next;
      oe_reg        <= oe_next;
    end
  end

  // Reset values match what the zeroed registers decode to,
  // so the outputs do not glitch when reset ends
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      e1_reg      <= {lccr_pkg::NCH{1'b1}};
      etsi_reg    <= '0;
      tx_ones_reg <= '0;
      rx_ais_reg  <= '0;
      code_reg    <= {lccr_pkg::NCH{lccr_pkg::LCCR_CODE_HDB3}};
      corner_reg  <= {lccr_pkg::NCH{lccr_pkg::CORNER_E1_LO_CHZ}};
      depth_reg   <= lccr_pkg::JAT_DEPTH_SHORT;
      place_reg   <= lccr_pkg::LCCR_PLACE_OFF;
    end else begin
      e1_reg      <= e1_next;
      etsi_reg    <= etsi_next;
      tx_ones_reg <= tx_ones_next;
      rx_ais_reg  <= rx_ais_next;
      code_reg    <= code_next;
      corner_reg  <= corner_next;
      depth_reg   <= depth_next;
      place_reg   <= place_next;
    end
  end

  assign host_data_out  = rdata_reg;
  assign host_data_oe   = oe_reg;
  assign loopback_en    = loopback_reg;
  assign chan_e1        = e1_reg;
  assign detect_etsi    = etsi_reg;
  assign tx_all_ones    = tx_ones_reg;
  assign rx_ais_insert  = rx_ais_reg;
  assign line_code      = code_reg;
  assign jat_fifo_depth = depth_reg;
  assign jat_corner_chz = corner_reg;
  assign jat_place      = place_reg;
  assign wave_auto_inc  = global_reg[lccr_pkg::GC_AUTO_INC];
  assign wave_phase_addr = wave_addr_reg;

  // Line-length store outputs come straight from its array flops
  always_comb begin
    for (int i = 0; i < lccr_pkg::NCH; i++) begin
      ll_impedance_int[i] = ll_bus.cfg[i][lccr_pkg::LL_INT_BIT];
      ll_len[i]           = ll_bus.cfg[i][lccr_pkg::LEN_W-1:0];
    end
  end

endmodule : lccr_channel_control_regs

// [tb/lccr_channel_control_regs_chk.sv]
// Port-level assertions for the control register bank
`timescale 1ns/1ps
module lccr_regs_chk (
  input logic                              mclk,
  input logic                              rst,
  input logic                              host_rd_n,
  input logic                              host_wr_n,
  input logic                              host_data_oe,
  input logic [7:0]                        chan_los,
  input logic                              wave_table_access,
  input logic [7:0]                        loopback_en,
  input logic [7:0]                        chan_e1,
  input logic [7:0]                        detect_etsi,
  input logic [7:0]                        tx_all_ones,
  input logic [7:0]                        rx_ais_insert,
  input logic [lccr_pkg::NCH-1:0][1:0]     line_code,
  input logic [6:0]                        jat_fifo_depth,
  input logic [lccr_pkg::NCH-1:0][9:0]     jat_corner_chz,
  input lccr_pkg::lccr_place_t             jat_place,
  input logic                              wave_auto_inc,
  input logic [7:0]                        wave_phase_addr
);
  logic [5:0] wr_hist_reg;
  logic [5:0] wr_hist_next;
  logic       quiet;
  logic       code_ok;
  logic       corner_ok;
  logic [7:0] hi;
  logic [7:0] lo;

  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);

  // A recent host write may still be landing, so step checks wait it out
  always_comb wr_hist_next = {wr_hist_reg[4:0], host_wr_n};
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) wr_hist_reg <= 6'h00;
    else wr_hist_reg <= wr_hist_next;
  end
  assign quiet = (&wr_hist_reg) & host_wr_n;

  always_comb begin
    code_ok = 1'b1;
    for (int n = 0; n < 8; n++) begin
      hi[n] = jat_corner_chz[n] === (chan_e1[n] ? 10'h0FA : 10'h2F4);
      lo[n] = jat_corner_chz[n] === (chan_e1[n] ? 10'h07D : 10'h17A);
      if (line_code[n] == 2'h0) code_ok &= line_code[0] == 2'h0;
      else code_ok &= line_code[n] == (chan_e1[n] ? 2'h2 : 2'h1);
    end
    corner_ok = ((hi | lo) == 8'hFF) && (hi == 8'h00 || hi == 8'hFF);
  end

  sequence s_rate_steady;
    chan_e1 == $past(chan_e1) && chan_e1 == $past(chan_e1, 2);
  endsequence

  property p_tx_all_ones;
    (tx_all_ones & ~$past(chan_los)) == 8'h00;
  endproperty
  a_tx_all_ones: assert property (p_tx_all_ones)
    else $error("all-ones sent on a channel without loss of signal");
  property p_rx_ais;
    rx_ais_insert == 8'h00 || rx_ais_insert == $past(chan_los);
  endproperty
  a_rx_ais: assert property (p_rx_ais)
    else $error("receive alarm insertion not uniform across channels");
  property p_t1_ansi;
    s_rate_steady |-> (detect_etsi & ~chan_e1) == 8'h00;
  endproperty
  a_t1_ansi: assert property (p_t1_ansi)
    else $error("ETSI detection chosen on a 1.544 Mbps channel");
  property p_line_code;
    s_rate_steady |-> code_ok;
  endproperty
  a_line_code: assert property (p_line_code)
    else $error("line code does not match rate and code select");
  property p_corner;
    s_rate_steady |-> corner_ok;
  endproperty
  a_corner: assert property (p_corner)
    else $error("corner frequency not a legal uniform choice");
  property p_fifo_place;
    jat_fifo_depth inside {7'h20, 7'h40} && jat_place != 2'b11;
  endproperty
  a_fifo_place: assert property (p_fifo_place)
    else $error("attenuator depth or placement out of range");
  property p_wave_step;
    quiet |=> wave_phase_addr == {$past(wave_phase_addr[7:4]),
      $past(wave_phase_addr[3:0]) +
      {3'h0, $past(wave_table_access & wave_auto_inc)}};
  endproperty
  a_wave_step: assert property (p_wave_step)
    else $error("phase address did not step as expected");
  property p_read_late;
    $rose(host_data_oe) |-> $past(host_rd_n, 2) == 1'b0;
  endproperty
  a_read_late: assert property (p_read_late)
    else $error("read data driven before the strobe was seen");
  property p_reset_out;
    $past(rst) |-> loopback_en == 8'h00 && tx_all_ones == 8'h00
      && host_data_oe == 1'b0 && wave_phase_addr == 8'h00;
  endproperty
  a_reset_out: assert property (p_reset_out)
    else $error("outputs not cleared after reset");
endmodule : lccr_regs_chk

bind lccr_channel_control_regs lccr_regs_chk u_chk (
  .mclk, .rst, .host_rd_n, .host_wr_n, .host_data_oe, .chan_los,
  .wave_table_access, .loopback_en, .chan_e1, .detect_etsi, .tx_all_ones,
  .rx_ais_insert, .line_code, .jat_fifo_depth, .jat_corner_chz, .jat_place,
  .wave_auto_inc, .wave_phase_addr
);

// [tb/test_lccr_channel_control_regs.sv]
// Self-checking bench for the control register bank
`timescale 1ns/1ps
module test_lccr_channel_control_regs;
  logic                   mclk, rst, host_cs_n, host_rd_n, host_wr_n;
  logic                   wave_table_access, host_data_oe, wave_auto_inc;
  logic [7:0]             host_addr, host_data_in, host_data_out, chan_los;
  logic [7:0]             loopback_en, chan_e1, detect_etsi, tx_all_ones;
  logic [7:0]             rx_ais_insert, wave_phase_addr, ll_impedance_int;
  logic [7:0][1:0]        line_code;
  logic [6:0]             jat_fifo_depth;
  logic [7:0][9:0]        jat_corner_chz;
  lccr_pkg::lccr_place_t  jat_place;
  logic [7:0][3:0]        ll_len;
  logic [7:0]             exp_q[$];
  logic [31:0]            seed;
  logic [7:0]             e1_exp, ae, v;
  logic                   oe_d;
  int                     miscompares, n_compared;
  logic [7:0]             glob [5] = '{8'h00, 8'h5D, 8'hCA, 8'h87, 8'h40};

  lccr_channel_control_regs dut (
    .mclk, .rst, .host_cs_n, .host_rd_n, .host_wr_n, .host_addr,
    .host_data_in, .host_data_out, .host_data_oe, .chan_los,
    .wave_table_access, .loopback_en, .chan_e1, .detect_etsi, .tx_all_ones,
    .rx_ais_insert, .line_code, .jat_fifo_depth, .jat_corner_chz,
    .jat_place, .wave_auto_inc, .wave_phase_addr, .ll_impedance_int, .ll_len
  );

  initial begin
    mclk = 1'b0;
    forever #2.5 mclk = ~mclk;
  end

  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    return s ^ (s << 5);
  endfunction : xs

  task automatic chk(input string nm, input logic [79:0] e, g);
    n_compared++;
    if (g !== e) begin
      miscompares++;
      $display("wrong value %s expected %0h seen %0h", nm, e, g);
    end
  endtask : chk

  task automatic cyc(input int n);
    repeat (n) @(posedge mclk);
  endtask : cyc

  task stop_test;
    $display("compared %0d miscompares %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : stop_test

  // Pins are synchronised inside, so strobes are held well past commit
  task automatic wr(input logic [7:0] a, d);
    host_addr <= a;
    host_data_in <= d;
    @(posedge mclk);
    host_cs_n <= 1'b0;
    host_wr_n <= 1'b0;
    cyc(5);
    host_cs_n <= 1'b1;
    host_wr_n <= 1'b1;
    cyc(5);
  endtask : wr

  task automatic rd(input logic [7:0] a, e);
    host_addr <= a;
    @(posedge mclk);
    host_cs_n <= 1'b0;
    host_rd_n <= 1'b0;
    exp_q.push_back(e);
    cyc(5);
    host_cs_n <= 1'b1;
    host_rd_n <= 1'b1;
    cyc(5);
  endtask : rd

  always @(negedge mclk) begin
    if (host_data_oe === 1'b1 && !oe_d) begin
      if (exp_q.size() == 0) chk("unexpected read", 1, 0);
      else chk("read data", exp_q.pop_front(), host_data_out);
    end
    oe_d = host_data_oe === 1'b1;
  end

  task automatic chk_glob(input logic [7:0] g);
    logic [15:0] code;
    logic [79:0] cz;
    for (int n = 0; n < 8; n++) begin
      code[2*n +: 2] = g[4] ? 2'h0 : (e1_exp[n] ? 2'h2 : 2'h1);
      cz[10*n +: 10] = e1_exp[n] ? (g[2] ? 10'h0FA : 10'h07D)
                                 : (g[2] ? 10'h2F4 : 10'h17A);
    end
    chk("chan_e1", e1_exp, chan_e1);
    chk("line_code", code, line_code);
    chk("corner", cz, jat_corner_chz);
    chk("depth", g[3] ? 7'h40 : 7'h20, jat_fifo_depth);
    chk("place", g[1:0] == 2'h1 ? 2'h1 : g[1:0] == 2'h3 ? 2'h2 : 2'h0,
        jat_place);
    chk("auto_inc", g[7], wave_auto_inc);
  endtask : chk_glob

  task automatic los_step(input logic [7:0] l, input logic g6);
    @(posedge mclk);
    chan_los <= l;
    @(posedge mclk);
    @(negedge mclk);
    chk("tx_all_ones", ae & l, tx_all_ones);
    chk("rx_ais", g6 ? l : 8'h00, rx_ais_insert);
  endtask : los_step

  task automatic pulse(input logic [7:0] e);
    @(posedge mclk);
    wave_table_access <= 1'b1;
    @(posedge mclk);
    wave_table_access <= 1'b0;
    @(negedge mclk);
    chk("phase", e, wave_phase_addr);
  endtask : pulse

  initial begin
    cyc(20000);
    miscompares++;
    stop_test();
  end

  initial begin
    rst = 1'b1;
    {host_cs_n, host_rd_n, host_wr_n} = 3'h7;
    host_addr = 8'h00;
    host_data_in = 8'h00;
    chan_los = 8'h00;
    wave_table_access = 1'b0;
    seed = 32'h5E6E;
    e1_exp = 8'hFF;
    ae = 8'h00;
    oe_d = 1'b0;
    cyc(20);
    rst <= 1'b0;
    cyc(2);
    chk_glob(8'h00);
    for (int a = 8'h0A; a <= 8'h11; a++) rd(a[7:0], 8'h00);
    wr(8'h10, 8'h03);
    wr(8'h11, 8'h12);
    wr(8'h10, 8'h07);
    wr(8'h11, 8'h08);
    e1_exp = 8'hF7;
    rd(8'h11, 8'h08);
    chk("ll_int", 8'h08, ll_impedance_int);
    chk("ll_len", 32'h8000_2000, ll_len);
    wr(8'h10, 8'h03);
    rd(8'h10, 8'h03);
    rd(8'h11, 8'h12);
    for (int i = 0; i < 3; i++) begin
      seed = xs(seed);
      v = seed[7:0];
      ae = seed[15:8];
      wr(8'h0C, v);
      rd(8'h0C, v);
      chk("loopback", v, loopback_en);
      wr(8'h0D, seed[23:16] | 8'h08);
      chk("etsi", seed[23:16] & e1_exp, detect_etsi);
      wr(8'h0E, ae);
      rd(8'h0E, ae);
    end
    foreach (glob[i]) begin
      wr(8'h0F, glob[i]);
      rd(8'h0F, glob[i]);
      chk_glob(glob[i]);
      seed = xs(seed);
      los_step(seed[7:0], glob[i][6]);
    end
    wr(8'h0F, 8'h80);
    wr(8'h17, 8'h5F);
    pulse(8'h50);
    pulse(8'h51);
    wr(8'h0F, 8'h00);
    pulse(8'h51);
    wr(8'h30, 8'hA5);
    rd(8'h30, 8'h00);
    wr(8'h0A, 8'h5A);
    e1_exp = 8'hFF;
    chk_glob(8'h00);
    chk("phase", 8'h00, wave_phase_addr);
    chk("ll_len", 32'h0, ll_len);
    for (int a = 8'h0C; a <= 8'h11; a++) rd(a[7:0], 8'h00);
    wr(8'h0C, 8'hFF);
    rst <= 1'b1;
    cyc(3);
    rst <= 1'b0;
    cyc(2);
    chk("loopback", 8'h00, loopback_en);
    rd(8'h0C, 8'h00);
    cyc(5);
    chk("reads left", 0, exp_q.size());
    stop_test();
  end
endmodule : test_lccr_channel_control_regs
